// ===== dftx_pkg.sv
// Operation
// - feac bits sent only in c-bit parity
// - message is code plus ten framing bits
// - rightmost bit, a one, goes first
// - one message bit per outbound frame
// - code in bits 6..1, rest read zero
// - processor runs only while enable set
// - writing go with enable set starts sending held code
// - message repeated ten times back to back
// - busy high until tenth repetition ends
// - tenth completion sets flag, gated interrupt
// - idle ones sent after completion indefinitely
package dftx_pkg;
  localparam logic [7:0] CSR_ADDR    = 8'h31;
  localparam logic [7:0] CODE_ADDR   = 8'h32;
  localparam int         BUSY_BIT    = 0;
  localparam int         GO_BIT      = 1;
  localparam int         EN_BIT      = 2;
  localparam int         FLAG_BIT    = 3;
  localparam int         IRQEN_BIT   = 4;
  localparam int         CODE_LSB    = 1;
  localparam int         MSG_BITS    = 16;
  localparam int         REPEATS     = 10;
  localparam logic [3:0] LAST_BIT    = 4'hF;
  localparam logic [3:0] LAST_REP    = 4'h9;
  localparam logic [7:0] FILL_ONES   = 8'hFF;
  localparam logic [7:0] RESET_BYTE  = 8'h00;

  // build the 16-bit message, bit 0 leaves first
  function automatic logic [MSG_BITS-1:0] dftx_msg(input logic [5:0] code);
    dftx_msg = {1'b0, code, 1'b0, FILL_ONES};
  endfunction : dftx_msg
endpackage : dftx_pkg

// ===== dftx_ser_if.sv
interface dftx_ser_if;
  logic       load;
  logic       abort;
  logic       tick;
  logic [5:0] code;
  logic       bit_val;
  logic       busy;
  logic       done;
  modport ctrl (output load, output abort, output tick, output code, input bit_val, input busy, input done);
  modport ser  (input load, input abort, input tick, input code, output bit_val, output busy, output done);
endinterface : dftx_ser_if

// ===== dftx_shifter.sv
module dftx_shifter
  import dftx_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic srst_in,
  dftx_ser_if.ser   sif
);
  logic [15:0] msg_r, msg_nxt;
  logic [3:0]  bit_cnt_r, bit_cnt_nxt;
  logic [3:0]  rep_cnt_r, rep_cnt_nxt;
  logic        busy_r, busy_nxt;
  logic        done_r, done_nxt;
  logic        bit_r, bit_nxt;

  // next state of the serialiser
  always_comb begin
    msg_nxt     = msg_r;
    bit_cnt_nxt = bit_cnt_r;
    rep_cnt_nxt = rep_cnt_r;
    busy_nxt    = busy_r;
    done_nxt    = 1'b0;
    bit_nxt     = bit_r;
    if (sif.abort) begin
      busy_nxt = 1'b0;
      if (sif.tick) begin
        bit_nxt = 1'b1;
      end
    end else if (sif.load) begin
      msg_nxt     = dftx_msg(sif.code);
      bit_cnt_nxt = 4'h0;
      rep_cnt_nxt = 4'h0;
      busy_nxt    = 1'b1;
    end else if (sif.tick) begin
      if (busy_r) begin
        bit_nxt = msg_r[0];
        msg_nxt = {msg_r[0], msg_r[15:1]}; // rotate so each repeat is the same word
        if (bit_cnt_r == LAST_BIT) begin
          bit_cnt_nxt = 4'h0;
          if (rep_cnt_r == LAST_REP) begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
          end else begin
            rep_cnt_nxt = rep_cnt_r + 4'h1;
          end
        end else begin
          bit_cnt_nxt = bit_cnt_r + 4'h1;
        end
      end else begin
        bit_nxt = 1'b1;
      end
    end
  end

  // register the serialiser state
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      msg_r     <= '1;
      bit_cnt_r <= 4'h0;
      rep_cnt_r <= 4'h0;
      busy_r    <= 1'b0;
      done_r    <= 1'b0;
      bit_r     <= 1'b1;
    end else begin
      msg_r     <= msg_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      rep_cnt_r <= rep_cnt_nxt;
      busy_r    <= busy_nxt;
      done_r    <= done_nxt;
      bit_r     <= bit_nxt;
    end
  end

  assign sif.bit_val = bit_r;
  assign sif.busy    = busy_r;
  assign sif.done    = done_r;
endmodule : dftx_shifter

// ===== dftx_top.sv
module dftx_top
  import dftx_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  output logic            irq_out,
  input  wire logic       frame_strobe_in,
  input  wire logic       cbit_mode_in,
  output logic            feac_bit_out,
  output logic            feac_valid_out
);
  // carrier between the register side and the serialiser
  dftx_ser_if sif ();

  // one strobe and address compare, shared by all four register decodes;
  // keeping it in one place stops read and write decodes drifting apart
  function automatic logic dftx_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] target);
    dftx_hit = strobe && (addr == target);
  endfunction : dftx_hit

  logic [5:0] code_r, code_nxt;
  logic       en_r, en_nxt;
  logic       go_r, go_nxt;
  logic       irq_en_r, irq_en_nxt;
  logic       flag_r, flag_nxt;
  logic       load_r, load_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       irq_r, irq_nxt;
  logic       valid_r, valid_nxt;
  logic       csr_wr, code_wr, csr_rd, code_rd;
  logic [7:0] status_byte, code_byte;

  // register bus decode; other addresses are ignored, reads included
  assign csr_wr  = dftx_hit(wr_in, addr_in, CSR_ADDR);
  assign code_wr = dftx_hit(wr_in, addr_in, CODE_ADDR);
  assign csr_rd  = dftx_hit(rd_in, addr_in, CSR_ADDR);
  assign code_rd = dftx_hit(rd_in, addr_in, CODE_ADDR);

  // read images of both registers; unused bits always read zero
  assign status_byte = {3'h0, irq_en_r, flag_r, en_r, go_r, sif.busy};
  assign code_byte   = {1'h0, code_r, 1'h0};

  // code word register; the two pad bits are never stored,
  // so they cannot leak back on a read
  always_comb begin
    code_nxt = code_r;
    if (code_wr) begin
      code_nxt = wdata_in[CODE_LSB +: 6];
    end
  end

  // register the code word
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      code_r <= 6'h00;
    end else begin
      code_r <= code_nxt;
    end
  end

  // processor enable; clearing it aborts a message in flight and
  // returns the link to idle ones at the next frame
  always_comb begin
    en_nxt = en_r;
    if (csr_wr) begin
      en_nxt = wdata_in[EN_BIT];
    end
  end

  // register the enable
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      en_r <= 1'b0;
    end else begin
      en_r <= en_nxt;
    end
  end

  // go only keeps what was last written; the start itself is a pulse
  always_comb begin
    go_nxt = go_r;
    if (csr_wr) begin
      go_nxt = wdata_in[GO_BIT];
    end
  end

  // register the go bit
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      go_r <= 1'b0;
    end else begin
      go_r <= go_nxt;
    end
  end

  // interrupt enable; it gates the pin only, the flag still records
  // every completion so polling software sees it either way
  always_comb begin
    irq_en_nxt = irq_en_r;
    if (csr_wr) begin
      irq_en_nxt = wdata_in[IRQEN_BIT];
    end
  end

  // register the interrupt enable
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_en_r <= 1'b0;
    end else begin
      irq_en_r <= irq_en_nxt;
    end
  end

  // start pulse: go only counts when the same write keeps enable set,
  // so a go written alone after a disable cannot restart a stale code
  always_comb begin
    load_nxt = 1'b0;
    if (csr_wr) begin
      load_nxt = wdata_in[GO_BIT] && wdata_in[EN_BIT];
    end
  end

  // register the start pulse
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      load_r <= 1'b0;
    end else begin
      load_r <= load_nxt;
    end
  end

  // completion flag: a status read clears it, but a completion in
  // the same cycle wins so no finished message is ever lost
  always_comb begin
    flag_nxt = flag_r;
    if (sif.done) begin
      flag_nxt = 1'b1;
    end else if (csr_rd) begin
      flag_nxt = 1'b0;
    end
  end

  // register the completion flag
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // interrupt follows the next flag and enable values, so it drops
  // in the same cycle as the read that clears the flag
  always_comb begin
    irq_nxt = flag_nxt && irq_en_nxt;
  end

  // register the interrupt pin
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // read data holds until the next mapped read; the status image is
  // taken before the clearing read updates the flag
  always_comb begin
    rdata_nxt = rdata_r;
    if (csr_rd) begin
      rdata_nxt = status_byte;
    end else if (code_rd) begin
      rdata_nxt = code_byte;
    end
  end

  // register the read data
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_r <= RESET_BYTE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // framing indication; a registered copy, so it trails the mode
  // input by one cycle like every other output
  always_comb begin
    valid_nxt = cbit_mode_in;
  end

  // register the framing indication
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      valid_r <= 1'b0;
    end else begin
      valid_r <= valid_nxt;
    end
  end

  // frames only advance the message in c-bit parity mode; other
  // framings pause the message rather than abort it
  assign sif.tick  = frame_strobe_in && cbit_mode_in;
  assign sif.load  = load_r;
  assign sif.abort = ~en_r;
  assign sif.code  = code_r;

  dftx_shifter u_shifter (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .sif     (sif)
  );

  // every output comes straight from a flop, the link bit from
  // the serialiser's own register
  assign rdata_out      = rdata_r;
  assign irq_out        = irq_r;
  assign feac_bit_out   = sif.bit_val; // shifter flop
  assign feac_valid_out = valid_r;
endmodule : dftx_top

// ===== dftx_rx_model.sv
module dftx_rx_model (
  input  wire logic        clk_in,
  input  wire logic        strobe_in,
  input  wire logic        cbit_in,
  input  wire logic        bit_in,
  output logic      [15:0] msg_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pend_r;
  // take the bit a cycle after its slot, once the sender has updated it
  always_ff @(posedge clk_in) begin
    pend_r <= strobe_in & cbit_in;
    if (pend_r)
      msg_out <= {bit_in, msg_out[15:1]};
  end
endmodule : dftx_rx_model

// ===== dftx_chk.sv
module dftx_chk (
  input wire logic       clk_in,
  input wire logic       srst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       irq_out,
  input wire logic       frame_strobe_in,
  input wire logic       cbit_mode_in,
  input wire logic       feac_bit_out,
  input wire logic       feac_valid_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ien_r;
  wire  w31 = wr_in && addr_in == 8'h31;
  wire  r31 = rd_in && addr_in == 8'h31;
  wire  r32 = rd_in && addr_in == 8'h32;
  wire  acc = frame_strobe_in && cbit_mode_in;
  // mirror of the irq enable, so gating is judged without peeking inside
  always_ff @(posedge clk_in)
    ien_r <= srst_in ? 1'b0 : (w31 ? wdata_in[4] : ien_r);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  a_pad_zero: assert property (r32 |=> !rdata_out[7] && !rdata_out[0]) else $error("pad bits");
  a_code_back: assert property (wr_in && addr_in == 8'h32 ##1 !wr_in ##1 r32 |=>
    rdata_out[6:1] == $past(wdata_in[6:1], 3)) else $error("code readback");
  a_strobe_only: assert property (!acc |=> $stable(feac_bit_out)) else $error("bit moved");
  a_cbit_valid: assert property (!$past(srst_in) |-> feac_valid_out == $past(cbit_mode_in))
    else $error("valid");
  a_go_busy: assert property (w31 && wdata_in[2:1] == 2'b11 ##1 !wr_in ##1 r31 |=> rdata_out[0])
    else $error("busy");
  a_off_ones: assert property (w31 && !wdata_in[2] ##[1:3] acc |=> feac_bit_out) else $error("off");
  a_irq_gate: assert property (irq_out |-> ien_r) else $error("irq gate");
  a_irq_last: assert property ($rose(irq_out) && $past(ien_r, 2) |-> !$past(feac_bit_out))
    else $error("irq early");
  c_go: cover property (w31 && wdata_in[2:1] == 2'b11);
  c_done: cover property ($rose(irq_out));
  c_pause: cover property (frame_strobe_in && !cbit_mode_in);
endmodule : dftx_chk
bind dftx_top dftx_chk u_chk (.clk_in, .srst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .irq_out,
  .frame_strobe_in, .cbit_mode_in, .feac_bit_out, .feac_valid_out);

// ===== dftx_top_tb.sv
module dftx_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        frame_strobe_in = 1'b0;
  logic        cbit_mode_in = 1'b1;
  logic [7:0]  addr_in = 8'h00;
  logic [7:0]  wdata_in = 8'h00;
  logic [7:0]  rdata_out;
  logic        irq_out;
  logic        feac_bit_out;
  logic        feac_valid_out;
  logic [15:0] msg;
  int          failures = 0;
  int          total_checks = 0;
  always #10 clk_in = ~clk_in;
  dftx_top uut (.clk_in, .srst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .irq_out,
    .frame_strobe_in, .cbit_mode_in, .feac_bit_out, .feac_valid_out);
  dftx_rx_model far (.clk_in, .strobe_in(frame_strobe_in), .cbit_in(cbit_mode_in), .bit_in(feac_bit_out),
    .msg_out(msg));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t bit got %b want %b", $time, got, exp);
    end
  endtask : chk_bit
  // one strobe a cycle, released at the next falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in) {wr_in, addr_in, wdata_in} = {1'b1, a, d};
    @(negedge clk_in) wr_in = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_in) {rd_in, addr_in} = {1'b1, a};
    @(negedge clk_in) rd_in = 1'b0;
    chk({8'h00, rdata_out}, {8'h00, e});
  endtask : rd
  // frame slots two cycles apart; the tail lets the far model catch the last bit
  task automatic frames(input int n, input logic cb);
    repeat (n) begin
      @(negedge clk_in) {frame_strobe_in, cbit_mode_in} = {1'b1, cb};
      @(negedge clk_in) frame_strobe_in = 1'b0;
    end
    repeat (2) @(negedge clk_in);
  endtask : frames
  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (4) @(negedge clk_in);
    srst_in = 1'b0;
    chk_bit(feac_bit_out, 1'b1);
    rd(8'h31, 8'h00);
    wr(8'h32, 8'hFF);
    rd(8'h32, 8'h7E);
    wr(8'h31, 8'h16);
    rd(8'h31, 8'h17);
    for (int i = 0; i < 10; i++) begin
      frames(1, 1'b0);
      chk_bit(feac_valid_out, 1'b0);
      frames(16, 1'b1);
      chk_bit(feac_valid_out, 1'b1);
      chk(msg, 16'h7EFF);
    end
    for (int k = 0; k < 8 && irq_out !== 1'b1; k++)
      @(negedge clk_in);
    chk_bit(irq_out, 1'b1);
    if (irq_out === 1'b1) begin
      rd(8'h31, 8'h1E);
      rd(8'h31, 8'h16);
      chk_bit(irq_out, 1'b0);
      frames(16, 1'b1);
      chk(msg, 16'hFFFF);
      $display("test repeat done");
      wr(8'h32, 8'h2A);
      wr(8'h31, 8'h06);
      for (int i = 0; i < 10; i++) begin
        frames(16, 1'b1);
        chk(msg, 16'h2AFF);
      end
      chk_bit(irq_out, 1'b0);
      rd(8'h31, 8'h0E);
      $display("test gated done");
      wr(8'h31, 8'h06);
      frames(16, 1'b1);
      chk(msg, 16'h2AFF);
      wr(8'h31, 8'h00);
      frames(16, 1'b1);
      chk(msg, 16'hFFFF);
      rd(8'h31, 8'h00);
      rd(8'h32, 8'h2A);
      rd(8'h33, 8'h2A);
      $display("test abort done");
    end
    conclude();
  end
endmodule : dftx_top_tb
